// ==== rtl/irq_rtc_params.svh ====
// Constants of the interrupt mask and seconds counter register slice.
// Assumes inclusion by bare name from the files that need it.
`ifndef IRQ_RTC_PARAMS_SVH
`define IRQ_RTC_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define IDX_GROUP4_MASK 14'h401c
`define IDX_PIN_MASK 14'h401d
`define IDX_WRITE_TRACKER 14'h4020
`define IDX_SECONDS_HIGH 14'h4021
`define IDX_SECONDS_LOW 14'h4022
`define IDX_CLOCK_CONTROL 14'h4025
`define IDX_GROUP4_STATUS 14'h4030
`define IDX_PIN_STATUS 14'h4031

// Field positions.
`define POS_CRYSTAL_START 7
`define POS_BUCK4_UV 3
`define POS_BUCK3_UV 2
`define POS_BUCK2_UV 1
`define POS_BUCK1_UV 0
`define POS_PIN_LOW 0
`define POS_PIN_HIGH 11
`define POS_TIME_VALID 15
`define POS_SYNC_BUSY 14

// Implemented bits and reset values.
`define GROUP4_BITS 16'h008f
`define PIN_BITS 16'h0fff
`define GROUP4_MASK_RESET 16'h008f
`define PIN_MASK_RESET 16'h0fff
`define STATUS_RESET 16'h0000
`define SECONDS_RESET 32'h0000_0000
`define TRACKER_RESET 16'h0000
`define LFSR_SEED 16'hace1

`endif

// ==== rtl/irq_rtc_pkg.sv ====
// Types shared by the interrupt mask and seconds counter register slice.
// Assumes the constants header is compiled alongside.
package irq_rtc_pkg;

	typedef logic [15:0] half_word_type;
	typedef logic [31:0] bus_word_type;

	typedef enum logic [3:0] {
		SEL_NONE = 4'h0,
		SEL_GROUP4_MASK = 4'h1,
		SEL_PIN_MASK = 4'h3,
		SEL_WRITE_TRACKER = 4'h2,
		SEL_SECONDS_HIGH = 4'h6,
		SEL_SECONDS_LOW = 4'h7,
		SEL_CLOCK_CONTROL = 4'h5,
		SEL_GROUP4_STATUS = 4'h4,
		SEL_PIN_STATUS = 4'hc
	} reg_sel_type;

endpackage

// ==== rtl/irq_mask_and_rtc_seconds_regs.sv ====
// APB register slice: interrupt masks, sticky event status and the
// 32-bit seconds counter with its write tracker.
// Assumes an APB master on REF_CLK and event and tick pins from other
// domains, each synchronised here before use.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irq_rtc_params.svh"

module irq_mask_and_rtc_seconds_regs
	import irq_rtc_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SECOND_TICK,
	input wire logic CRYSTAL_START_EVT,
	input wire logic [3:0] BUCK_UV_EVT,
	input wire logic [11:0] PIN_EVT,
	output logic IRQ,
	output logic [31:0] SECONDS,
	output logic TIME_VALID,
	output logic SYNC_BUSY
);

	// Byte addresses of the registers.
	localparam bus_word_type ADDR_GROUP4_MASK =
		{16'h0000, `IDX_GROUP4_MASK, 2'b00};
	localparam bus_word_type ADDR_PIN_MASK =
		{16'h0000, `IDX_PIN_MASK, 2'b00};
	localparam bus_word_type ADDR_WRITE_TRACKER =
		{16'h0000, `IDX_WRITE_TRACKER, 2'b00};
	localparam bus_word_type ADDR_SECONDS_HIGH =
		{16'h0000, `IDX_SECONDS_HIGH, 2'b00};
	localparam bus_word_type ADDR_SECONDS_LOW =
		{16'h0000, `IDX_SECONDS_LOW, 2'b00};
	localparam bus_word_type ADDR_CLOCK_CONTROL =
		{16'h0000, `IDX_CLOCK_CONTROL, 2'b00};
	localparam bus_word_type ADDR_GROUP4_STATUS =
		{16'h0000, `IDX_GROUP4_STATUS, 2'b00};
	localparam bus_word_type ADDR_PIN_STATUS =
		{16'h0000, `IDX_PIN_STATUS, 2'b00};
	localparam half_word_type GROUP4_BITS = `GROUP4_BITS;
	localparam half_word_type PIN_BITS = `PIN_BITS;

	// Stored state.
	half_word_type group4_mask;
	half_word_type pin_mask;
	half_word_type group4_status;
	half_word_type pin_status;
	half_word_type write_tracker;
	half_word_type lfsr;
	logic [31:0] seconds;
	logic time_valid;
	logic [31:0] read_data;

	// Synchronisers: first stage, second stage, previous value.
	logic [16:0] evt_meta;
	logic [16:0] evt_sync;
	logic [16:0] evt_prev;
	logic tick_meta;
	logic tick_sync;
	logic tick_prev;

	// Next values.
	half_word_type next_group4_mask;
	half_word_type next_pin_mask;
	half_word_type next_group4_status;
	half_word_type next_pin_status;
	half_word_type next_write_tracker;
	half_word_type next_lfsr;
	logic [31:0] next_seconds;
	logic next_time_valid;

	// Bus phases.
	wire setup_phase;
	wire access_phase;
	wire access_write;
	wire access_read;
	assign setup_phase = PSEL & ~PENABLE;
	assign access_phase = PSEL & PENABLE;
	assign access_write = access_phase & PWRITE;
	assign access_read = access_phase & ~PWRITE;

	// Address decode.
	wire hit_group4_mask;
	wire hit_pin_mask;
	wire hit_write_tracker;
	wire hit_seconds_high;
	wire hit_seconds_low;
	wire hit_clock_control;
	wire hit_group4_status;
	wire hit_pin_status;
	wire hit_any;
	wire hit_writable;
	assign hit_group4_mask = PADDR == ADDR_GROUP4_MASK;
	assign hit_pin_mask = PADDR == ADDR_PIN_MASK;
	assign hit_write_tracker = PADDR == ADDR_WRITE_TRACKER;
	assign hit_seconds_high = PADDR == ADDR_SECONDS_HIGH;
	assign hit_seconds_low = PADDR == ADDR_SECONDS_LOW;
	assign hit_clock_control = PADDR == ADDR_CLOCK_CONTROL;
	assign hit_group4_status = PADDR == ADDR_GROUP4_STATUS;
	assign hit_pin_status = PADDR == ADDR_PIN_STATUS;
	assign hit_writable = hit_group4_mask | hit_pin_mask |
		hit_seconds_high | hit_seconds_low;
	assign hit_any = hit_writable | hit_write_tracker |
		hit_clock_control | hit_group4_status | hit_pin_status;

	// Writes to read-only registers and all unmapped accesses are refused and leave state untouched.
	wire access_error;
	wire write_ok;
	assign access_error = access_phase & (~hit_any | (PWRITE & ~hit_writable));
	assign write_ok = access_write & ~access_error;

	wire write_group4_mask;
	wire write_pin_mask;
	wire write_seconds_high;
	wire write_seconds_low;
	wire write_seconds;
	wire read_group4_status;
	wire read_pin_status;
	assign write_group4_mask = write_ok & hit_group4_mask;
	assign write_pin_mask = write_ok & hit_pin_mask;
	assign write_seconds_high = write_ok & hit_seconds_high;
	assign write_seconds_low = write_ok & hit_seconds_low;
	assign write_seconds = write_seconds_high | write_seconds_low;
	assign read_group4_status = access_read & hit_group4_status;
	assign read_pin_status = access_read & hit_pin_status;

	// Byte lanes 0 and 1 carry the 16-bit registers.
	function automatic half_word_type merge_lanes(
		input half_word_type old_value,
		input logic [31:0] data,
		input logic [3:0] strobe
	);
		half_word_type merged;
		merged = old_value;
		if (strobe[0]) begin
			merged[7:0] = data[7:0];
		end
		if (strobe[1]) begin
			merged[15:8] = data[15:8];
		end
		return merged;
	endfunction

	// Register select for the read path.
	reg_sel_type read_sel;
	assign read_sel = hit_group4_mask ? SEL_GROUP4_MASK :
		hit_pin_mask ? SEL_PIN_MASK :
		hit_write_tracker ? SEL_WRITE_TRACKER :
		hit_seconds_high ? SEL_SECONDS_HIGH :
		hit_seconds_low ? SEL_SECONDS_LOW :
		hit_clock_control ? SEL_CLOCK_CONTROL :
		hit_group4_status ? SEL_GROUP4_STATUS :
		hit_pin_status ? SEL_PIN_STATUS : SEL_NONE;

	// Event edges.
	wire [16:0] evt_rise;
	wire [7:0] group4_evt;
	wire [11:0] pin_evt;
	wire [15:0] group4_set;
	wire [15:0] pin_set;
	wire tick_rise;
	assign evt_rise = evt_sync & ~evt_prev;
	assign tick_rise = tick_sync & ~tick_prev;
	assign group4_evt = {evt_rise[16], 3'b000, evt_rise[15:12]};
	assign pin_evt = evt_rise[11:0];
	assign group4_set = {8'h00, group4_evt};
	assign pin_set = {4'h0, pin_evt};

	// Sticky status; a read clears only the bits it returned, so an event
	// landing after the setup capture survives, and an edge always wins.
	generate
		for (genvar i = 0; i < 16; i++) begin : g_status
			assign next_group4_status[i] = GROUP4_BITS[i] &
				(group4_set[i] | (group4_status[i] &
				~(read_group4_status & read_data[i])));
			assign next_pin_status[i] = PIN_BITS[i] &
				(pin_set[i] | (pin_status[i] &
				~(read_pin_status & read_data[i])));
		end
	endgenerate

	// Masks keep only their implemented bits.
	assign next_group4_mask = write_group4_mask ?
		(merge_lanes(group4_mask, PWDATA, PSTRB) & GROUP4_BITS) :
		group4_mask;
	assign next_pin_mask = write_pin_mask ?
		(merge_lanes(pin_mask, PWDATA, PSTRB) & PIN_BITS) :
		pin_mask;

	// A written half takes the bus value; a tick in that cycle is dropped,
	// since software has just defined the time itself.
	wire [31:0] seconds_written;
	assign seconds_written = {
		write_seconds_high ?
			merge_lanes(seconds[31:16], PWDATA, PSTRB) : seconds[31:16],
		write_seconds_low ?
			merge_lanes(seconds[15:0], PWDATA, PSTRB) : seconds[15:0]
	};
	assign next_seconds = write_seconds ? seconds_written :
		tick_rise ? seconds + 32'h0000_0001 : seconds;

	// Free-running LFSR; its state is sampled on each seconds write.
	wire lfsr_feedback;
	assign lfsr_feedback = lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10];
	assign next_lfsr = {lfsr[14:0], lfsr_feedback};
	assign next_write_tracker = write_seconds ? lfsr : write_tracker;
	assign next_time_valid = time_valid | write_seconds;

	// Busy while a tick is crossing into the counter, so a write then
	// could collide with the increment.
	wire sync_busy;
	assign sync_busy = tick_sync ^ tick_prev;

	// Read data multiplexer.
	logic [31:0] next_read_data;
	always_comb begin
		next_read_data = 32'h0000_0000;
		case (read_sel)
			SEL_GROUP4_MASK: begin
				next_read_data = {16'h0000, group4_mask};
			end
			SEL_PIN_MASK: begin
				next_read_data = {16'h0000, pin_mask};
			end
			SEL_WRITE_TRACKER: begin
				next_read_data = {16'h0000, write_tracker};
			end
			SEL_SECONDS_HIGH: begin
				next_read_data = {16'h0000, seconds[31:16]};
			end
			SEL_SECONDS_LOW: begin
				next_read_data = {16'h0000, seconds[15:0]};
			end
			SEL_CLOCK_CONTROL: begin
				next_read_data[`POS_TIME_VALID] = time_valid;
				next_read_data[`POS_SYNC_BUSY] = sync_busy;
			end
			SEL_GROUP4_STATUS: begin
				next_read_data = {16'h0000, group4_status};
			end
			SEL_PIN_STATUS: begin
				next_read_data = {16'h0000, pin_status};
			end
			default: begin
				next_read_data = 32'h0000_0000;
			end
		endcase
	end

	// Synchronisers.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			evt_meta <= 17'h00000;
			evt_sync <= 17'h00000;
			evt_prev <= 17'h00000;
		end else begin
			evt_meta <= {CRYSTAL_START_EVT, BUCK_UV_EVT, PIN_EVT};
			evt_sync <= evt_meta;
			evt_prev <= evt_sync;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			tick_meta <= 1'b0;
			tick_sync <= 1'b0;
			tick_prev <= 1'b0;
		end else begin
			tick_meta <= SECOND_TICK;
			tick_sync <= tick_meta;
			tick_prev <= tick_sync;
		end
	end

	// Interrupt masks and status.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			group4_mask <= `GROUP4_MASK_RESET;
			pin_mask <= `PIN_MASK_RESET;
			group4_status <= `STATUS_RESET;
			pin_status <= `STATUS_RESET;
		end else begin
			group4_mask <= next_group4_mask;
			pin_mask <= next_pin_mask;
			group4_status <= next_group4_status;
			pin_status <= next_pin_status;
		end
	end

	// Seconds counter and its companions.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			seconds <= `SECONDS_RESET;
			write_tracker <= `TRACKER_RESET;
			lfsr <= `LFSR_SEED;
			time_valid <= 1'b0;
		end else begin
			seconds <= next_seconds;
			write_tracker <= next_write_tracker;
			lfsr <= next_lfsr;
			time_valid <= next_time_valid;
		end
	end

	// Read data is captured in the setup phase so it is stable in access.
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			read_data <= 32'h0000_0000;
		end else if (setup_phase & ~PWRITE) begin
			read_data <= next_read_data;
		end
	end

	// Every transfer completes in its first access cycle.
	assign PREADY = 1'b1;
	assign PSLVERR = access_error;
	assign PRDATA = read_data;

	// A set mask bit removes its source from the combined request.
	wire [15:0] group4_pending;
	wire [15:0] pin_pending;
	assign group4_pending = group4_status & ~group4_mask;
	assign pin_pending = pin_status & ~pin_mask;
	assign IRQ = |{group4_pending, pin_pending};

	assign SECONDS = seconds;
	assign TIME_VALID = time_valid;
	assign SYNC_BUSY = sync_busy;

endmodule

`default_nettype wire

// ==== tb/irq_rtc_monitor.sv ====
// Checker of the register slice: bus answers, seconds counter and flags.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "irq_rtc_params.svh"
module irq_rtc_monitor (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic IRQ,
	input wire logic [31:0] SECONDS,
	input wire logic TIME_VALID
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	wire acc = PSEL && PENABLE;
	wire sec_wr = acc && PWRITE &&
		(PADDR == {16'h0000, `IDX_SECONDS_HIGH, 2'b00} ||
		PADDR == {16'h0000, `IDX_SECONDS_LOW, 2'b00});
	wire mask_acc = acc && (PADDR == {16'h0000, `IDX_GROUP4_MASK, 2'b00} ||
		PADDR == {16'h0000, `IDX_PIN_MASK, 2'b00});
	wire ro_wr = acc && PWRITE &&
		PADDR == {16'h0000, `IDX_WRITE_TRACKER, 2'b00};
	property p_ready; acc |-> PREADY; endproperty
	a_ready: assert property (p_ready) else $error("no ready in access");
	property p_idle; !acc |-> !PSLVERR; endproperty
	a_idle: assert property (p_idle) else $error("error outside access");
	property p_ro; ro_wr |-> PSLVERR; endproperty
	a_ro: assert property (p_ro) else $error("tracker write taken");
	property p_mask; mask_acc |-> !PSLVERR; endproperty
	a_mask: assert property (p_mask) else $error("mask refused");
	property p_upper; acc && !PWRITE |-> PRDATA[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper data");
	property p_step;
		!$past(sec_wr) && SECONDS != $past(SECONDS) |->
			SECONDS == $past(SECONDS) + 32'h1;
	endproperty
	a_step: assert property (p_step) else $error("bad step");
	property p_vset; sec_wr |=> TIME_VALID; endproperty
	a_vset: assert property (p_vset) else $error("valid not set");
	property p_vkeep; TIME_VALID |=> TIME_VALID; endproperty
	a_vkeep: assert property (p_vkeep) else $error("valid lost");
	property p_vclr; !TIME_VALID && !sec_wr |=> !TIME_VALID; endproperty
	a_vclr: assert property (p_vclr) else $error("valid early");
	property p_irq0; $rose(RST_N) |-> !IRQ; endproperty
	a_irq0: assert property (p_irq0) else $error("irq at reset");
	c_secwr: cover property (sec_wr ##1 TIME_VALID);
	c_irq: cover property ($rose(IRQ));
	c_tick: cover property (!sec_wr ##1 SECONDS != $past(SECONDS));
endmodule
bind irq_mask_and_rtc_seconds_regs irq_rtc_monitor u_irq_rtc_monitor (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .IRQ(IRQ), .SECONDS(SECONDS),
	.TIME_VALID(TIME_VALID));
`default_nettype wire

// ==== tb/test_irq_mask_and_rtc_seconds_regs.sv ====
// Self-checking bench of the interrupt mask and seconds register slice.
// Assumes the design, its package and constants header compile first.
`timescale 1ns/1ps
`default_nettype none
`include "irq_rtc_params.svh"
module test_irq_mask_and_rtc_seconds_regs;
	logic REF_CLK, RST_N, PSEL, PENABLE, PWRITE, SECOND_TICK, CRYSTAL_START_EVT;
	logic [31:0] PADDR, PWDATA, PRDATA, SECONDS;
	logic [3:0] PSTRB, BUCK_UV_EVT;
	logic [11:0] PIN_EVT;
	logic PREADY, PSLVERR, IRQ, TIME_VALID, SYNC_BUSY, err;
	logic [31:0] rd;
	logic [15:0] gm, pm, hi, trk;
	logic [13:0] mi;
	int n_errors = 0, n_tests = 0, cycles = 0, pos;
	irq_mask_and_rtc_seconds_regs u_irq_mask_and_rtc_seconds_regs (
		.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.SECOND_TICK(SECOND_TICK), .CRYSTAL_START_EVT(CRYSTAL_START_EVT),
		.BUCK_UV_EVT(BUCK_UV_EVT), .PIN_EVT(PIN_EVT), .IRQ(IRQ),
		.SECONDS(SECONDS), .TIME_VALID(TIME_VALID), .SYNC_BUSY(SYNC_BUSY));
	task automatic results();
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [13:0] idx,
		input logic [31:0] d);
		@(posedge REF_CLK);
		while (w && SYNC_BUSY) @(posedge REF_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= {16'h0000, idx, 2'b00};
		PWDATA <= d;
		PSTRB <= 4'hf;
		@(posedge REF_CLK);
		PENABLE <= 1'b1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp,
		input string what);
		apb(1'b0, idx, 32'h0);
		check(what, exp, rd);
	endtask
	task automatic fire(input int i);
		{CRYSTAL_START_EVT, BUCK_UV_EVT, PIN_EVT} <=
			17'h1 << ((i < 4) ? i + 12 : (i == 4) ? 16 : i - 5);
		repeat (2) @(posedge REF_CLK);
		{BUCK_UV_EVT, CRYSTAL_START_EVT, PIN_EVT} <= '0;
		repeat (4) @(posedge REF_CLK);
	endtask
	initial begin
		REF_CLK = 1'b0;
		forever #50 REF_CLK = ~REF_CLK;
	end
	// A hung handshake would otherwise stall the run with no verdict.
	always @(posedge REF_CLK) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		void'($urandom(32'hbb26));
		{RST_N, PSEL, PENABLE, PWRITE, SECOND_TICK, CRYSTAL_START_EVT} = '0;
		{PADDR, PWDATA, PSTRB, BUCK_UV_EVT, PIN_EVT} = '0;
		repeat (4) @(posedge REF_CLK);
		RST_N <= 1'b1;
		rdchk(`IDX_GROUP4_MASK, 32'h008f, "group4_mask");
		rdchk(`IDX_PIN_MASK, 32'h0fff, "pin_mask");
		check("time_valid", 32'h0, TIME_VALID);
		repeat (4) begin
			gm = 16'($urandom);
			pm = 16'($urandom);
			apb(1'b1, `IDX_GROUP4_MASK, {16'($urandom), gm});
			apb(1'b1, `IDX_PIN_MASK, {16'h0000, pm});
			rdchk(`IDX_GROUP4_MASK, gm & 16'h008f, "group4_mask");
			rdchk(`IDX_PIN_MASK, pm & 16'h0fff, "pin_mask");
		end
		apb(1'b1, `IDX_GROUP4_MASK, 32'hffff);
		apb(1'b1, `IDX_PIN_MASK, 32'hffff);
		for (int i = 0; i < 17; i++) begin
			pos = (i < 4) ? i : (i == 4) ? 7 : i - 5;
			mi = (i < 5) ? `IDX_GROUP4_MASK : `IDX_PIN_MASK;
			fire(i);
			@(negedge REF_CLK);
			check("irq_masked", 32'h0, IRQ);
			apb(1'b1, mi, ~(32'h1 << pos));
			repeat (2) @(negedge REF_CLK);
			check("irq_open", 32'h1, IRQ);
			rdchk(mi + 14'h0014, 32'h1 << pos, "status");
			repeat (2) @(negedge REF_CLK);
			check("irq_clear", 32'h0, IRQ);
			apb(1'b1, mi, 32'hffff);
		end
		hi = 16'($urandom);
		apb(1'b1, `IDX_SECONDS_HIGH, {16'h0000, hi});
		@(negedge REF_CLK);
		check("time_valid", 32'h1, TIME_VALID);
		rdchk(`IDX_CLOCK_CONTROL, 32'h8000, "clock_control");
		apb(1'b0, `IDX_WRITE_TRACKER, 32'h0);
		check("tracker_new", 32'h1, rd[15:0] != 16'h0000);
		trk = rd[15:0];
		apb(1'b1, `IDX_SECONDS_LOW, 32'hfffe);
		apb(1'b0, `IDX_WRITE_TRACKER, 32'h0);
		check("tracker_new", 32'h1, rd[15:0] != trk);
		trk = rd[15:0];
		apb(1'b1, `IDX_WRITE_TRACKER, $urandom);
		check("ro_error", 32'h1, err);
		rdchk(`IDX_WRITE_TRACKER, trk, "tracker_kept");
		repeat (3) begin
			SECOND_TICK <= 1'b1;
			repeat (2) @(posedge REF_CLK);
			@(negedge REF_CLK);
			check("sync_busy", 32'h1, SYNC_BUSY);
			repeat (2) @(posedge REF_CLK);
			SECOND_TICK <= 1'b0;
			repeat (4) @(posedge REF_CLK);
		end
		rdchk(`IDX_SECONDS_HIGH, {16'h0000, hi + 16'h1}, "seconds_high");
		rdchk(`IDX_SECONDS_LOW, 32'h0001, "seconds_low");
		check("seconds", {hi + 16'h1, 16'h0001}, SECONDS);
		rdchk(14'h3fff, 32'h0, "unmapped");
		check("unmapped_error", 32'h1, err);
		RST_N <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		RST_N <= 1'b1;
		@(negedge REF_CLK);
		check("time_valid", 32'h0, TIME_VALID);
		results();
	end
endmodule
`default_nettype wire
